// >>> inc/synth_load_pkg.sv
package synth_load_pkg;

  // ********************************************************
  // control word layout
  // ********************************************************
  localparam int          WORD_W      = 24;
  localparam int          MSB_BIT     = 23;
  localparam int          ADDR_HI     = 22;
  localparam int          ADDR_LO     = 20;
  localparam logic [2:0]  ADDR_B      = 3'h0;
  localparam logic [2:0]  ADDR_C      = 3'h1;
  localparam logic [2:0]  ADDR_D      = 3'h2;
  localparam logic [2:0]  ADDR_E      = 3'h3;
  localparam int          NUM_WORDS   = 5;
  localparam int          IDX_A       = 0;
  localparam int          IDX_B       = 1;
  localparam int          IDX_C       = 2;
  localparam int          IDX_D       = 3;
  localparam int          IDX_E       = 4;
  localparam int          NIB_W       = 4;
  localparam int          SPD_W       = 8;
  localparam int          G1_LO       = 19;
  localparam int          G2_LO       = 16;
  localparam int          EM_BIT      = 0;
  localparam int          EA_BIT      = 1;
  localparam logic [23:0] WORD_RESET  = 24'h000000;

  // ********************************************************
  // serial timing, aclk at 125 MHz
  // ********************************************************
  localparam int          CLK_NS        = 8;
  localparam int          SCLK_HALF_NS  = 50;
  localparam int          STROBE_SU_NS  = 30;
  localparam int          STROBE_HI_NS  = 30;
  localparam int          STROBE_LO_NS  = 30;
  localparam int          CNT_W         = 4;
  localparam logic [3:0]  SCLK_HALF_CYC = 4'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  STROBE_SU_CYC = 4'((STROBE_SU_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  STROBE_HI_CYC = 4'((STROBE_HI_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  STROBE_LO_CYC = 4'((STROBE_LO_NS + CLK_NS - 1) / CLK_NS);

  // ********************************************************
  // host register map
  // ********************************************************
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  REG_TX_WORD  = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_PIN_CTRL = 8'h08;
  localparam int          ST_BUSY      = 0;
  localparam int          ST_COUNT_LO  = 8;
  localparam int          PIN_MAIN_BIT = 0;
  localparam int          PIN_AUX_BIT  = 1;
  localparam logic [1:0]  PIN_RESET    = 2'h3;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;

  typedef enum logic [1:0] {
    MODE_BOTH_ON,
    MODE_MAIN_ON,
    MODE_AUX_ON,
    MODE_SHUTDOWN
  } chip_mode_t;

endpackage : synth_load_pkg

// >>> inc/serial_link_if.sv
`timescale 1ns/10ps

interface serial_link_if;
  logic sclk;                // serial clock
  logic sdata;               // serial data, lsb first
  logic strobe;              // load strobe
  logic main_loop_enable_n;  // main loop enable pin
  logic aux_loop_enable_n;   // aux loop enable pin

  modport host (
    output sclk,
    output sdata,
    output strobe,
    output main_loop_enable_n,
    output aux_loop_enable_n
  );

  modport device (
    input sclk,
    input sdata,
    input strobe,
    input main_loop_enable_n,
    input aux_loop_enable_n
  );
endinterface : serial_link_if

// >>> verilog/synth_load_device.sv
`timescale 1ns/10ps

module synth_load_device (
  input  wire logic                          aclk,          // system clock
  input  wire logic                          aresetn,       // sync reset, low
  input  wire logic                          ce,            // clock enable
  serial_link_if.device                      link,          // three-wire port and pins
  output      logic [synth_load_pkg::NUM_WORDS-1:0][synth_load_pkg::WORD_W-1:0]
                                             ctrl_words,    // held control words A..E
  output      logic [synth_load_pkg::SPD_W-1:0] speedup_len, // speed-up cycles
  output      logic                          word_loaded,   // pulse per strobe
  output      logic                          main_cp_on,    // main charge pump on
  output      logic                          main_div_on,   // main divider on
  output      logic                          aux_cp_on,     // aux charge pump driving
  output      logic                          aux_cp_hiz,    // aux pump tristate
  output      logic                          aux_div_on,    // aux divider on
  output      synth_load_pkg::chip_mode_t    chip_mode      // pin decoded mode
);
  import synth_load_pkg::*;

  // ********************************************************
  // input synchronisers
  // ********************************************************
  logic [4:0] sync1_reg, sync1_next;
  logic [4:0] sync2_reg, sync2_next;
  logic [1:0] hist_reg, hist_next;

  // two flops per pin, then edge history
  always_comb begin
    sync1_next = sync1_reg;
    sync2_next = sync2_reg;
    hist_next  = hist_reg;
    if (ce) begin
      sync1_next = {link.sclk, link.sdata, link.strobe,
                    link.main_loop_enable_n, link.aux_loop_enable_n};
      sync2_next = sync1_reg;
      hist_next  = {sync2_reg[4], sync2_reg[2]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 5'h03;
      sync2_reg <= 5'h03;
      hist_reg  <= 2'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      hist_reg  <= hist_next;
    end
  end

  logic sclk_s;
  logic sdata_s;
  logic strobe_s;
  logic main_n_s;
  logic aux_n_s;
  logic sclk_rise;
  logic strobe_rise;

  // synchronised levels and edges
  assign sclk_s      = sync2_reg[4];
  assign sdata_s     = sync2_reg[3];
  assign strobe_s    = sync2_reg[2];
  assign main_n_s    = sync2_reg[1];
  assign aux_n_s     = sync2_reg[0];
  assign sclk_rise   = sclk_s & ~hist_reg[1];
  assign strobe_rise = strobe_s & ~hist_reg[0];

  // ********************************************************
  // shift register
  // ********************************************************
  logic [WORD_W-1:0] shift_reg, shift_next;

  // new bit enters at the top, first bit ends at bit 0
  always_comb begin
    shift_next = shift_reg;
    if (ce && sclk_rise) begin
      shift_next = {sdata_s, shift_reg[WORD_W-1:1]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_reg <= WORD_RESET;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // ********************************************************
  // word decode and storage
  // ********************************************************
  logic [NUM_WORDS-1:0] hit;

  always_comb begin
    hit = '0;
    if (shift_reg[MSB_BIT]) begin
      hit[IDX_A] = 1'b1;
    end else begin
      hit[IDX_B] = (shift_reg[ADDR_HI:ADDR_LO] == ADDR_B);
      hit[IDX_C] = (shift_reg[ADDR_HI:ADDR_LO] == ADDR_C);
      hit[IDX_D] = (shift_reg[ADDR_HI:ADDR_LO] == ADDR_D);
      hit[IDX_E] = (shift_reg[ADDR_HI:ADDR_LO] == ADDR_E);
    end
  end

  logic [NUM_WORDS-1:0][WORD_W-1:0] word_reg;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WORDS; gi++) begin : g_word
      logic [WORD_W-1:0] word_next;

      // only the serial port writes words
      always_comb begin
        word_next = word_reg[gi];
        if (ce && strobe_rise && hit[gi]) begin
          word_next = shift_reg;
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          word_reg[gi] <= WORD_RESET;
        end else begin
          word_reg[gi] <= word_next;
        end
      end
    end
  endgenerate

  // ********************************************************
  // loop enables and outputs
  // ********************************************************
  logic                          em;
  logic                          ea;
  logic                          shutdown;
  logic [SPD_W-1:0]              spd_next;
  logic                          loaded_next;
  logic                          main_cp_next;
  logic                          main_div_next;
  logic                          aux_cp_next;
  logic                          aux_div_next;
  logic                          aux_hiz_next;
  chip_mode_t                    mode_next;

  assign em       = word_reg[IDX_D][EM_BIT];
  assign ea       = word_reg[IDX_D][EA_BIT];
  assign shutdown = main_n_s & aux_n_s;

  // mode decode and stage gating
  always_comb begin
    // high nibble in B, low nibble in A
    spd_next = {word_reg[IDX_B][G2_LO +: NIB_W], word_reg[IDX_A][G1_LO +: NIB_W]};
    loaded_next = ce & strobe_rise;
    // flag and main pin gate pump and divider
    main_cp_next  = em & ~main_n_s;
    main_div_next = em & ~main_n_s;
    // aux pin only gates aux pump
    aux_cp_next   = ea & ~aux_n_s;
    aux_hiz_next  = ~aux_cp_next;
    // shutdown turns aux divider off too
    aux_div_next  = ea & ~shutdown;
    // main pin high keeps aux running
    unique case ({main_n_s, aux_n_s})
      2'b00:   mode_next = MODE_BOTH_ON;
      2'b01:   mode_next = MODE_MAIN_ON;
      2'b10:   mode_next = MODE_AUX_ON;
      2'b11:   mode_next = MODE_SHUTDOWN;
    endcase
  end

  logic [SPD_W-1:0] spd_reg;
  logic             loaded_reg;
  logic             main_cp_reg;
  logic             main_div_reg;
  logic             aux_cp_reg;
  logic             aux_hiz_reg;
  logic             aux_div_reg;
  chip_mode_t       mode_reg;

  // output registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spd_reg      <= 8'h00;
      loaded_reg   <= 1'b0;
      main_cp_reg  <= 1'b0;
      main_div_reg <= 1'b0;
      aux_cp_reg   <= 1'b0;
      aux_hiz_reg  <= 1'b1;
      aux_div_reg  <= 1'b0;
      mode_reg     <= MODE_SHUTDOWN;
    end else if (ce) begin
      spd_reg      <= spd_next;
      loaded_reg   <= loaded_next;
      main_cp_reg  <= main_cp_next;
      main_div_reg <= main_div_next;
      aux_cp_reg   <= aux_cp_next;
      aux_hiz_reg  <= aux_hiz_next;
      aux_div_reg  <= aux_div_next;
      mode_reg     <= mode_next;
    end
  end

  // outputs straight from flops
  assign ctrl_words  = word_reg;
  assign speedup_len = spd_reg;
  assign word_loaded = loaded_reg;
  assign main_cp_on  = main_cp_reg;
  assign main_div_on = main_div_reg;
  assign aux_cp_on   = aux_cp_reg;
  assign aux_cp_hiz  = aux_hiz_reg;
  assign aux_div_on  = aux_div_reg;
  assign chip_mode   = mode_reg;

endmodule : synth_load_device

// >>> verilog/synth_load_host.sv
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps

module synth_load_host (
  input  wire logic                              aclk,     // system clock
  input  wire logic                              aresetn,  // sync reset, low
  input  wire logic                              ce,       // clock enable
  input  wire logic [synth_load_pkg::ADDR_W-1:0] awaddr,   // write address
  input  wire logic                              awvalid,  // write address valid
  output      logic                              awready,  // write address ready
  input  wire logic [31:0]                       wdata,    // write data
  input  wire logic [3:0]                        wstrb,    // byte enables
  input  wire logic                              wvalid,   // write data valid
  output      logic                              wready,   // write data ready
  output      logic [1:0]                        bresp,    // write response
  output      logic                              bvalid,   // response valid
  input  wire logic                              bready,   // response ready
  input  wire logic [synth_load_pkg::ADDR_W-1:0] araddr,   // read address
  input  wire logic                              arvalid,  // read address valid
  output      logic                              arready,  // read address ready
  output      logic [31:0]                       rdata,    // read data
  output      logic [1:0]                        rresp,    // read response
  output      logic                              rvalid,   // read valid
  input  wire logic                              rready,   // read ready
  serial_link_if.host                            link      // three-wire port and pins
);
  import synth_load_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_SETUP, H_STB_HI, H_STB_LO} hstate_t;

  // ********************************************************
  // register slave
  // ********************************************************
  logic              awready_reg, awready_next, wready_reg, wready_next;
  logic              bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic              rvalid_reg, rvalid_next;
  logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [ADDR_W-1:0] waddr_reg, waddr_next;
  logic [31:0]       wdat_reg, wdat_next, rdata_reg, rdata_next;
  logic [3:0]        wstb_reg, wstb_next;
  logic [23:0]       txw_reg, txw_next;
  logic [1:0]        pins_reg, pins_next;
  logic [7:0]        sent_reg;
  logic              busy;
  logic              launch;
  hstate_t           st_reg;

  assign busy = (st_reg != H_IDLE);

  // address and data taken in either order, write once both held
  always_comb begin
    awready_next = awready_reg;
    wready_next  = wready_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    waddr_next   = waddr_reg;
    wdat_next    = wdat_reg;
    wstb_next    = wstb_reg;
    txw_next     = txw_reg;
    pins_next    = pins_reg;
    launch       = 1'b0;
    if (awvalid && awready_reg) begin
      waddr_next   = awaddr;
      awready_next = 1'b0;
    end
    if (wvalid && wready_reg) begin
      wdat_next   = wdata;
      wstb_next   = wstrb;
      wready_next = 1'b0;
    end
    if (!awready_reg && !wready_reg && !bvalid_reg) begin
      bvalid_next = 1'b1;
      bresp_next  = RESP_OKAY;
      if (waddr_reg == REG_TX_WORD) begin
        if (busy) begin
          bresp_next = RESP_SLVERR;
        end else begin
          for (int i = 0; i < 3; i++) begin
            if (wstb_reg[i]) begin
              txw_next[i*8 +: 8] = wdat_reg[i*8 +: 8];
            end
          end
          launch = 1'b1;
        end
      end else if (waddr_reg == REG_PIN_CTRL) begin
        if (wstb_reg[0]) begin
          pins_next = wdat_reg[1:0];
        end
      end else begin
        bresp_next = (waddr_reg == REG_STATUS) ? RESP_SLVERR : RESP_DECERR;
      end
    end
    if (bvalid_reg && bready) begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end
    if (arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = RESP_OKAY;
      rdata_next   = 32'h00000000;
      unique case (araddr)
        REG_TX_WORD:  rdata_next[23:0] = txw_reg;
        REG_STATUS:   rdata_next = {16'h0000, sent_reg, 7'h00, busy};
        REG_PIN_CTRL: rdata_next[1:0] = pins_reg;
        default:      rresp_next = RESP_DECERR;
      endcase
    end
    if (rvalid_reg && rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
    if (!ce) begin
      launch = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h00000000;
      waddr_reg   <= 8'h00;
      wdat_reg    <= 32'h00000000;
      wstb_reg    <= 4'h0;
      txw_reg     <= WORD_RESET;
      pins_reg    <= PIN_RESET;
    end else if (ce) begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
      waddr_reg   <= waddr_next;
      wdat_reg    <= wdat_next;
      wstb_reg    <= wstb_next;
      txw_reg     <= txw_next;
      pins_reg    <= pins_next;
    end
  end

  // ********************************************************
  // serial sender
  // ********************************************************
  hstate_t           st_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [4:0]        bit_reg, bit_next;
  logic [23:0]       sh_reg, sh_next;
  logic              sclk_reg, sclk_next, sdat_reg, sdat_next, stb_reg, stb_next;
  logic [7:0]        sent_next;

  // each word closed by a strobe
  always_comb begin
    st_next   = st_reg;
    cnt_next  = (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : cnt_reg;
    bit_next  = bit_reg;
    sh_next   = sh_reg;
    sclk_next = sclk_reg;
    sdat_next = sdat_reg;
    stb_next  = stb_reg;
    sent_next = sent_reg;
    unique case (st_reg)
      H_IDLE: begin
        if (launch) begin
          sh_next   = txw_next;
          sdat_next = txw_next[0];
          bit_next  = 5'h00;
          cnt_next  = SCLK_HALF_CYC - 4'h1;
          st_next   = H_LOW;
        end
      end
      H_LOW: begin
        if (cnt_reg == 4'h0) begin
          sclk_next = 1'b1;
          cnt_next  = SCLK_HALF_CYC - 4'h1;
          st_next   = H_HIGH;
        end
      end
      H_HIGH: begin
        if (cnt_reg == 4'h0) begin
          sclk_next = 1'b0;
          if (bit_reg == 5'h17) begin
            cnt_next = STROBE_SU_CYC - 4'h1;
            st_next  = H_SETUP;
          end else begin
            bit_next  = bit_reg + 5'h01;
            sh_next   = {1'b0, sh_reg[23:1]};
            sdat_next = sh_reg[1];
            cnt_next  = SCLK_HALF_CYC - 4'h1;
            st_next   = H_LOW;
          end
        end
      end
      H_SETUP: begin
        if (cnt_reg == 4'h0) begin
          stb_next = 1'b1;
          cnt_next = STROBE_HI_CYC - 4'h1;
          st_next  = H_STB_HI;
        end
      end
      H_STB_HI: begin
        if (cnt_reg == 4'h0) begin
          stb_next = 1'b0;
          cnt_next = STROBE_LO_CYC - 4'h1;
          st_next  = H_STB_LO;
        end
      end
      H_STB_LO: begin
        if (cnt_reg == 4'h0) begin
          sent_next = sent_reg + 8'h01;
          st_next   = H_IDLE;
        end
      end
      default: st_next = H_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg   <= H_IDLE;
      cnt_reg  <= 4'h0;
      bit_reg  <= 5'h00;
      sh_reg   <= WORD_RESET;
      sclk_reg <= 1'b0;
      sdat_reg <= 1'b0;
      stb_reg  <= 1'b0;
      sent_reg <= 8'h00;
    end else if (ce) begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      sclk_reg <= sclk_next;
      sdat_reg <= sdat_next;
      stb_reg  <= stb_next;
      sent_reg <= sent_next;
    end
  end

  // outputs straight from flops
  assign awready                 = awready_reg;
  assign wready                  = wready_reg;
  assign bvalid                  = bvalid_reg;
  assign bresp                   = bresp_reg;
  assign arready                 = arready_reg;
  assign rvalid                  = rvalid_reg;
  assign rresp                   = rresp_reg;
  assign rdata                   = rdata_reg;
  assign link.sclk               = sclk_reg;
  assign link.sdata              = sdat_reg;
  assign link.strobe             = stb_reg;
  assign link.main_loop_enable_n = pins_reg[PIN_MAIN_BIT];
  assign link.aux_loop_enable_n  = pins_reg[PIN_AUX_BIT];

endmodule : synth_load_host

// >>> testbench/synth_load_chk.sv
`timescale 1ns/10ps
module synth_load_chk (
  input wire logic                   aclk,               // clock
  input wire logic                   aresetn,            // reset, low
  input wire logic                   sclk,               // serial clock
  input wire logic                   sdata,              // serial data
  input wire logic                   strobe,             // load strobe
  input wire logic                   main_loop_enable_n, // main pin
  input wire logic                   aux_loop_enable_n,  // aux pin
  input wire logic [4:0][23:0]       ctrl_words,         // held words
  input wire logic                   word_loaded,        // load pulse
  input wire logic                   main_cp_on,         // main pump
  input wire logic                   aux_cp_hiz,         // aux tristate
  input wire logic                   aux_div_on,         // aux divider
  input wire synth_load_pkg::chip_mode_t chip_mode       // pin mode
);
  import synth_load_pkg::*;

  logic [23:0] sh_reg;
  logic [23:0] cap_reg;
  logic        sclk_q;
  logic        strobe_q;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // shadow shift, lsb first, captured at strobe rise
  always_ff @(posedge aclk) begin
    sclk_q <= sclk;
    strobe_q <= strobe;
    if (sclk && !sclk_q) sh_reg <= {sdata, sh_reg[23:1]};
    if (strobe && !strobe_q) cap_reg <= sh_reg;
  end

  // pins held long enough to pass the synchroniser
  sequence pins_held(bit m, bit a);
    (main_loop_enable_n == m && aux_loop_enable_n == a)[*5];
  endsequence

  chk_mode_all_on:
    assert property (pins_held(0, 0) |-> chip_mode == MODE_BOTH_ON) else $error("mode 00");
  chk_aux_pump_hiz:
    assert property (pins_held(0, 1) |-> chip_mode == MODE_MAIN_ON && aux_cp_hiz)
      else $error("mode 01");
  chk_main_loop_off:
    assert property (pins_held(1, 0) |-> chip_mode == MODE_AUX_ON && !main_cp_on)
      else $error("mode 10");
  chk_shutdown_all_off:
    assert property (pins_held(1, 1) |-> chip_mode == MODE_SHUTDOWN && !aux_div_on
      && !main_cp_on) else $error("mode 11");
  chk_strobe_loads:
    assert property ($rose(strobe) |-> ##[3:6] word_loaded) else $error("no load");
  chk_hold_no_strobe:
    assert property (!strobe[*8] |=> $stable(ctrl_words) && !word_loaded)
      else $error("words moved");
  chk_word_a_decode:
    assert property (word_loaded && cap_reg[MSB_BIT] |-> ctrl_words[IDX_A] == cap_reg)
      else $error("word a");
  chk_word_d_decode:
    assert property (word_loaded && !cap_reg[MSB_BIT] && cap_reg[ADDR_HI:ADDR_LO] == ADDR_D
      |-> ctrl_words[IDX_D] == cap_reg) else $error("word d");
endmodule : synth_load_chk

// >>> testbench/synth_serial_control_load_bench.sv
`timescale 1ns/10ps
module synth_serial_control_load_bench;
  import synth_load_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, word_loaded, main_cp_on, main_div_on;
  logic aux_cp_on, aux_cp_hiz, aux_div_on;
  logic [7:0] awaddr, araddr, speedup_len;
  logic [1:0] bresp, rresp;
  logic [31:0] wdata, rdata, seed;
  logic [NUM_WORDS-1:0][WORD_W-1:0] ctrl_words;
  logic [23:0] exp_w [NUM_WORDS];
  chip_mode_t chip_mode;
  int err_total, tests_run;

  serial_link_if link ();
  synth_load_host synth_load_host_inst (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .link);
  synth_load_device synth_load_device_inst (.aclk, .aresetn, .ce(1'b1), .link, .ctrl_words,
    .speedup_len, .word_loaded, .main_cp_on, .main_div_on, .aux_cp_on, .aux_cp_hiz,
    .aux_div_on, .chip_mode);
  synth_load_chk synth_load_chk_inst (.aclk, .aresetn, .sclk(link.sclk), .sdata(link.sdata),
    .strobe(link.strobe), .main_loop_enable_n(link.main_loop_enable_n),
    .aux_loop_enable_n(link.aux_loop_enable_n), .ctrl_words, .word_loaded, .main_cp_on,
    .aux_cp_hiz, .aux_div_on, .chip_mode);

  // 125 MHz clock
  always #4 aclk = ~aclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int exp_idx(input logic [23:0] w);
    if (w[MSB_BIT]) return IDX_A;
    if (w[ADDR_HI:ADDR_LO] <= ADDR_E) return IDX_B + int'(w[ADDR_HI:ADDR_LO]);
    return -1;
  endfunction : exp_idx
  // mode and enables with both flags of word d set
  function automatic logic [6:0] exp_pins(input logic [1:0] m);
    return {m[0], m[1], ~m[0], ~m[0], ~m[1], m[1], ~(m[0] & m[1])};
  endfunction : exp_pins

  task automatic print_verdict();
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      print_verdict();
    end
  endtask : tmo
  // one write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    r = bresp;
    tmo(n, 100);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready && arvalid) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    tmo(n, 100);
  endtask : rd
  // poll until the serial send is over
  task automatic idle();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      rd(REG_STATUS, d, r);
      n++;
    end while (d[ST_BUSY] !== 1'b0 && n < 300);
    tmo(n, 300);
  endtask : idle

  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [23:0] w;
    logic [3:0] hdr [6];
    {aclk, aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready} = 2'h3;
    seed = 32'd94166;
    err_total = 0;
    tests_run = 0;
    // words a, b, c, d, e sent
    // address 5 only as test traffic
    hdr = '{4'h8, 4'h0, 4'h1, 4'h2, 4'h3, 4'h5};
    foreach (exp_w[k]) exp_w[k] = WORD_RESET;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(REG_PIN_CTRL, d, r);
    chk(d, {30'h0, PIN_RESET});
    chk(32'(chip_mode), 32'(MODE_SHUTDOWN));
    rd(8'h0c, d, r);
    chk({d[29:0], r}, {30'h0, RESP_DECERR});
    wr(REG_STATUS, 32'h0, r);
    chk(32'(r), 32'(RESP_SLVERR));
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      w = {hdr[i % 6], seed[19:0]};
      if (w[23:20] == {1'b0, ADDR_D}) w[1:0] = 2'h3;
      wr(REG_TX_WORD, {8'h0, w}, r);
      chk(32'(r), 32'(RESP_OKAY));
      if (i == 0) wr(REG_TX_WORD, 32'h0, r);
      if (i == 0) chk(32'(r), 32'(RESP_SLVERR));
      idle();
      if (exp_idx(w) >= 0) exp_w[exp_idx(w)] = w;
      foreach (exp_w[k]) chk(32'(ctrl_words[k]), 32'(exp_w[k]));
      chk(32'(speedup_len),
        32'({exp_w[IDX_B][G2_LO+:NIB_W], exp_w[IDX_A][G1_LO+:NIB_W]}));
    end
    for (int m = 0; m < 4; m++) begin
      wr(REG_PIN_CTRL, m, r);
      repeat (8) @(posedge aclk);
      chk(32'({chip_mode, main_cp_on, main_div_on, aux_cp_on, aux_cp_hiz, aux_div_on}),
        32'(exp_pins(m[1:0])));
    end
    print_verdict();
  end
endmodule : synth_serial_control_load_bench
